// >>> pkg/ops_pkg.sv
/*
  ops_pkg: constants shared by the output protection supervisor,
  its fault filters and its restart timer.
  Assumes a 100 MHz pclk; APB offsets are byte addresses.
*/
package ops_pkg;
  // timing, times in their own unit, counts derived from the clock
  localparam int unsigned OPS_CLK_HZ        = 100_000_000;
  localparam int unsigned OPS_OVP_FILT_NS   = 30_000;
  localparam int unsigned OPS_CC_FILT_NS    = 127_000;
  localparam int unsigned OPS_OCP_BLANK_US  = 20_000;
  localparam int unsigned OPS_RESTART_MS    = 1_000;
  localparam int unsigned OPS_OVP_FILT_CYC  = (OPS_OVP_FILT_NS * (OPS_CLK_HZ / 1_000_000)
                                               + 999) / 1000;
  localparam int unsigned OPS_CC_FILT_CYC   = (OPS_CC_FILT_NS * (OPS_CLK_HZ / 1_000_000)
                                               + 999) / 1000;
  localparam int unsigned OPS_OCP_BLANK_CYC = OPS_OCP_BLANK_US * (OPS_CLK_HZ / 1_000_000);
  localparam int unsigned OPS_RESTART_CYC   = OPS_RESTART_MS * (OPS_CLK_HZ / 1_000);

  // register offsets
  localparam logic [7:0] OPS_OFS_PROT   = 8'h00;
  localparam logic [7:0] OPS_OFS_LEVEL  = 8'h04;
  localparam logic [7:0] OPS_OFS_TEMP   = 8'h08;
  localparam logic [7:0] OPS_OFS_PDO    = 8'h0C;
  localparam logic [7:0] OPS_OFS_DEFOUT = 8'h10;
  localparam logic [7:0] OPS_OFS_STATUS = 8'h14;
  localparam logic [7:0] OPS_OFS_FLOG   = 8'h18;

  // protection enable bits in the PROT register
  localparam int OPS_EN_OVP = 0;
  localparam int OPS_EN_OTPI = 1;
  localparam int OPS_EN_UVP = 2;
  localparam int OPS_EN_CCOV = 3;
  localparam int OPS_EN_LATCH = 4;
  localparam logic [4:0] OPS_PROT_RST = 5'h07;  // cc overvoltage off, safe restart

  // fault vector positions
  localparam int OPS_F_OVP = 0;
  localparam int OPS_F_OCP = 1;
  localparam int OPS_F_OTPI = 2;
  localparam int OPS_F_OTPE = 3;
  localparam int OPS_F_UVP = 4;
  localparam int OPS_F_OPEN = 5;
  localparam int OPS_F_CCOV = 6;
  localparam int OPS_F_SOFT = 7;
  localparam int OPS_F_LOCK = 8;
  localparam int OPS_NF = 9;
  localparam logic [8:0] OPS_LATCHABLE = 9'h0DF;  // all but open supply and lockout

  // level selections and reset values
  localparam logic [1:0] OPS_GPIO_THERMISTOR_WITH_TRIP_MODE = 2'h2;
  localparam logic [1:0] OPS_DIV_2P5 = 2'h1;
  localparam logic [1:0] OPS_DIV_5P476 = 2'h2;
  localparam logic [8:0] OPS_V_9V = 9'h0B4;      // 50 mV units
  localparam logic [8:0] OPS_V_CAP_13V = 9'h104;
  localparam logic [8:0] OPS_V_CAP_6V = 9'h078;
  localparam logic [8:0] OPS_V_3V = 9'h03C;
  localparam logic [7:0] OPS_DEFV_MAX = 8'h8C;   // 10 V
  localparam logic [7:0] OPS_DEFV_RST = 8'h28;   // 5 V
  localparam logic [7:0] OPS_DEFI_MAX = 8'hEB;   // 5 A
  localparam logic [7:0] OPS_DEFI_RST = 8'h87;   // 3 A
  localparam logic [4:0] OPS_OTPI_MAX = 5'h19;   // 135 C
  localparam logic [4:0] OPS_OTPI_RST = 5'h14;   // 113 C
  localparam logic [10:0] OPS_OTPI_BASE = 11'h10E;  // 27.0 C in tenths
  localparam logic [10:0] OPS_OTPI_STEP = 11'h02B;  // 4.3 C in tenths
  localparam logic [6:0] OPS_OTPE_MIN = 7'h3E;   // 62 C
  localparam logic [6:0] OPS_OTPE_MAX = 7'h6F;   // 111 C
  localparam logic [6:0] OPS_OTPE_RST = 7'h5A;   // 90 C
  localparam int OPS_PPS_MAX = 4;
  localparam logic [7:0] OPS_PCT_120 = 8'h78;
  localparam logic [7:0] OPS_PCT_125 = 8'h7D;
  localparam logic [7:0] OPS_PCT_130 = 8'h82;
  localparam logic [7:0] OPS_PCT_60 = 8'h3C;
  localparam logic [7:0] OPS_PCT_70 = 8'h46;
  localparam logic [7:0] OPS_PCT_80 = 8'h50;
  localparam logic [7:0] OPS_PCT_90 = 8'h5A;
endpackage

// >>> core/ops_filter.sv
/*
  ops_filter: continuous-assertion filter for one fault comparator.
  Assumes the comparator input is synchronous to pclk.
*/
`timescale 1ns/10ps
`default_nettype none
module ops_filter (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        raw,
  input  wire logic [31:0] limit,
  output logic             trip
);
  logic [31:0] cnt_r;
  logic [31:0] cnt_nxt;

  // any gap in the input restarts the count, so only unbroken faults trip
  always_comb begin
    cnt_nxt = cnt_r;
    if (!raw) begin
      cnt_nxt = 32'h0000_0000;
    end else if (cnt_r < limit) begin
      cnt_nxt = cnt_r + 32'h0000_0001;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= 32'h0000_0000;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  assign trip = raw && (cnt_r >= limit);
endmodule
`default_nettype wire

// >>> core/ops_restart_timer.sv
/*
  ops_restart_timer: one-shot safe-restart timer.
  Assumes start is a one-cycle pulse; a new start reloads the count.
*/
`timescale 1ns/10ps
`default_nettype none
module ops_restart_timer (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        start,
  input  wire logic [31:0] limit,
  output logic             done,
  output logic             expire
);
  logic [31:0] cnt_r;
  logic [31:0] cnt_nxt;
  logic        run_r;
  logic        run_nxt;

  // count while running; expire pulses on the last count
  always_comb begin
    cnt_nxt = cnt_r;
    run_nxt = run_r;
    if (start) begin
      cnt_nxt = 32'h0000_0000;
      run_nxt = 1'b1;
    end else if (run_r) begin
      cnt_nxt = cnt_r + 32'h0000_0001;
      if (cnt_nxt >= limit) begin
        run_nxt = 1'b0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= 32'h0000_0000;
      run_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      run_r <= run_nxt;
    end
  end

  assign expire = run_r && !run_nxt && !start;
  assign done   = !run_r;
endmodule
`default_nettype wire

// >>> core/ops_supervisor.sv
/*
  ops_supervisor: output protection supervisor with APB configuration.
  Assumes fault comparators and measurements are synchronous to pclk,
  and that the analog side applies the threshold percentages it is given.
*/
// The register addresses and the APB register port were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
// Notes on behaviour
// - any enabled fault opens the load switch at once, after its filter only
// - reclose only after fault clears, target back at default, delay elapsed
// - during safe restart keep regulating, target forced to default output voltage
// - while restart pending, discharge sink on when supply above 1.05 of default
// - fault starts restart timer, expiry issues a full restart sequence
// - latched option keeps most protections off until power is cycled
// - lockout opens switch, returns all settings to initial values
// - overvoltage percent: 125 below 9 V, 120 from 9 V, or 120/125/130
// - overvoltage trips only after an unbroken 30 us above threshold
// - overcurrent trips only for trip-mode PDO after 20 ms blanking
// - internal overtemperature above programmed level, 27 to 135 C, 4.3 C steps
// - external overtemperature only in thermistor trip mode, 62 to 111 C
// - lost supply pin forces the load switch open
// - undervoltage default 60 percent, safe restart, never below lockout
// - undervoltage choices off/60/70/80 fixed, off/70/80/90 programmable
// - shorted output lockout opens switch, reenables after restart time
// - cc pin overvoltage off by default, safe restart when enabled
// - cc pin overvoltage trips after 127 us above 4.5 V
// - bad cc soft-short impedance opens the load switch
// - first PDO fixed 5 V 3 A, others 3 to 20 V
// - per-PDO programmable flag, at most four programmable PDOs
// - default output 3 to 10 V, default current 0.3 to 5 A
// - divider 5.476 caps output at 13 V, 2.5 caps at 6 V
module ops_supervisor
  import ops_pkg::*;
#(
  parameter int unsigned CC_FILT_CYC   = OPS_CC_FILT_CYC,
  parameter int unsigned OCP_BLANK_CYC = OPS_OCP_BLANK_CYC,
  parameter int unsigned RESTART_CYC   = OPS_RESTART_CYC
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic             pslverr,
  output logic [31:0]      prdata,
  input  wire logic        supply_lockout,
  input  wire logic        open_supply_guard,
  input  wire logic        ovp_above,
  input  wire logic        ocp_above,
  input  wire logic        uvp_below,
  input  wire logic        cc1_above,
  input  wire logic        cc2_above,
  input  wire logic        cc_soft_short_guard,
  input  wire logic        vcc_above_105,
  input  wire logic        vcc_at_default,
  input  wire logic [10:0] die_temp_dc,
  input  wire logic [6:0]  ntc_temp_c,
  input  wire logic [8:0]  req_voltage,
  input  wire logic [2:0]  active_pdo,
  output logic             load_switch_on,
  output logic             discharge_en,
  output logic             target_default,
  output logic [8:0]       voltage_target,
  output logic [7:0]       ovp_pct,
  output logic [7:0]       uvp_pct,
  output logic             restart_seq
);
  typedef enum logic [2:0] {
    ST_RUN   = 3'h1,
    ST_TRIP  = 3'h2,
    ST_LATCH = 3'h4
  } ops_state_t;

  // threshold percent for overvoltage from selection and voltage target
  function automatic logic [7:0] ops_ovp_pct(input logic [1:0] sel, input logic [8:0] v);
    unique case (sel)
      2'h1:    ops_ovp_pct = OPS_PCT_120;
      2'h2:    ops_ovp_pct = OPS_PCT_125;
      2'h3:    ops_ovp_pct = OPS_PCT_130;
      default: ops_ovp_pct = (v < OPS_V_9V) ? OPS_PCT_125 : OPS_PCT_120;
    endcase
  endfunction

  // undervoltage percent; zero means off
  function automatic logic [7:0] ops_uvp_pct(input logic [1:0] sel, input logic pps);
    unique case (sel)
      2'h1:    ops_uvp_pct = pps ? OPS_PCT_70 : OPS_PCT_60;
      2'h2:    ops_uvp_pct = pps ? OPS_PCT_80 : OPS_PCT_70;
      2'h3:    ops_uvp_pct = pps ? OPS_PCT_90 : OPS_PCT_80;
      default: ops_uvp_pct = 8'h00;
    endcase
  endfunction

  function automatic logic [3:0] ops_popcnt(input logic [6:0] m);
    logic [3:0] n;
    n = 4'h0;
    for (int i = 0; i < 7; i++) begin
      n = n + {3'h0, m[i]};
    end
    ops_popcnt = n;
  endfunction

  // configuration registers
  logic [4:0]  prot_r, prot_nxt;
  logic [1:0]  ovp_sel_r, ovp_sel_nxt;
  logic [1:0]  uvp_sel_r, uvp_sel_nxt;
  logic [1:0]  gpio_mode_r, gpio_mode_nxt;
  logic [1:0]  div_sel_r, div_sel_nxt;
  logic [4:0]  otpi_code_r, otpi_code_nxt;
  logic [6:0]  otpe_lvl_r, otpe_lvl_nxt;
  logic [6:0]  trip_mask_r, trip_mask_nxt;
  logic [6:0]  pps_mask_r, pps_mask_nxt;
  logic [7:0]  defv_r, defv_nxt;
  logic [7:0]  defi_r, defi_nxt;
  logic [8:0]  flog_r, flog_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  logic        slverr_r, slverr_nxt;
  ops_state_t  state_r, state_nxt;

  logic        wr_en;
  logic        rd_setup;
  logic        mapped;
  logic [8:0]  fault;
  logic        any_fault;
  logic        f_ovp, f_ocp, f_ccov;
  logic        tmr_start, tmr_done, tmr_expire;
  logic [10:0] otpi_dc;
  logic [8:0]  vcap;

  assign wr_en    = psel && penable && pwrite;
  assign rd_setup = psel && !penable;
  assign mapped   = (paddr <= OPS_OFS_FLOG) && (paddr[1:0] == 2'h0);
  assign pready   = 1'b1;
  assign pslverr  = slverr_r && psel && penable;
  assign prdata   = prdata_r;

  // filtered fault detectors
  ops_filter u_ovp_filt (
    .pclk    (pclk),
    .presetn (presetn),
    .raw     (ovp_above && prot_r[OPS_EN_OVP]),
    .limit   (OPS_OVP_FILT_CYC),
    .trip    (f_ovp)
  );
  ops_filter u_ocp_filt (
    .pclk    (pclk),
    .presetn (presetn),
    .raw     (ocp_above && trip_mask_r[active_pdo]),
    .limit   (OCP_BLANK_CYC),
    .trip    (f_ocp)
  );
  ops_filter u_cc_filt (
    .pclk    (pclk),
    .presetn (presetn),
    .raw     ((cc1_above || cc2_above) && prot_r[OPS_EN_CCOV]),
    .limit   (CC_FILT_CYC),
    .trip    (f_ccov)
  );

  // internal temperature level in tenths of a degree
  assign otpi_dc = OPS_OTPI_BASE + OPS_OTPI_STEP * {6'h00, otpi_code_r};

  // fault vector; lockout, open supply and soft short act with no filter
  always_comb begin
    fault = 9'h000;
    fault[OPS_F_OVP]  = f_ovp;
    fault[OPS_F_OCP]  = f_ocp;
    fault[OPS_F_OTPI] = prot_r[OPS_EN_OTPI] && (die_temp_dc > otpi_dc);
    fault[OPS_F_OTPE] = (gpio_mode_r == OPS_GPIO_THERMISTOR_WITH_TRIP_MODE) && (ntc_temp_c > otpe_lvl_r);
    fault[OPS_F_UVP]  = prot_r[OPS_EN_UVP] && (uvp_pct != 8'h00) && uvp_below;
    fault[OPS_F_OPEN] = open_supply_guard;
    fault[OPS_F_CCOV] = f_ccov;
    fault[OPS_F_SOFT] = cc_soft_short_guard;
    fault[OPS_F_LOCK] = supply_lockout;
  end
  assign any_fault = |fault;

  // protection sequencer
  always_comb begin
    state_nxt = state_r;
    tmr_start = 1'b0;
    unique case (state_r)
      ST_RUN: begin
        if (any_fault) begin
          tmr_start = 1'b1;
          if (prot_r[OPS_EN_LATCH] && |(fault & OPS_LATCHABLE)) begin
            state_nxt = ST_LATCH;
          end else begin
            state_nxt = ST_TRIP;
          end
        end
      end
      ST_TRIP: begin
        // reclose only once the output is back at a safe default level
        if (tmr_done && !any_fault && vcc_at_default && !vcc_above_105) begin
          state_nxt = ST_RUN;
        end
      end
      ST_LATCH: begin
        if (supply_lockout) begin
          tmr_start = 1'b1;
          state_nxt = ST_TRIP;
        end
      end
      default: state_nxt = ST_TRIP;
    endcase
  end

  ops_restart_timer u_timer (
    .pclk    (pclk),
    .presetn (presetn),
    .start   (tmr_start),
    .limit   (RESTART_CYC),
    .done    (tmr_done),
    .expire  (tmr_expire)
  );

  // switch and regulation outputs; the switch opens in the fault's own cycle
  assign load_switch_on = (state_r == ST_RUN) && !any_fault;
  assign target_default = (state_r != ST_RUN);
  assign discharge_en   = (state_r == ST_TRIP) && vcc_above_105;
  assign restart_seq    = tmr_expire && (state_r == ST_TRIP);

  // divider-dependent ceiling on the requested output voltage
  always_comb begin
    unique case (div_sel_r)
      OPS_DIV_5P476: vcap = OPS_V_CAP_13V;
      OPS_DIV_2P5:   vcap = OPS_V_CAP_6V;
      default:       vcap = 9'h190;
    endcase
  end
  assign voltage_target = target_default ? (OPS_V_3V + {1'b0, defv_r})
                        : ((req_voltage > vcap) ? vcap : req_voltage);
  assign ovp_pct = ops_ovp_pct(ovp_sel_r, voltage_target);
  assign uvp_pct = ops_uvp_pct(uvp_sel_r, pps_mask_r[active_pdo]);

  // register writes, field clamps and the sticky fault log
  always_comb begin
    prot_nxt      = prot_r;
    ovp_sel_nxt   = ovp_sel_r;
    uvp_sel_nxt   = uvp_sel_r;
    gpio_mode_nxt = gpio_mode_r;
    div_sel_nxt   = div_sel_r;
    otpi_code_nxt = otpi_code_r;
    otpe_lvl_nxt  = otpe_lvl_r;
    trip_mask_nxt = trip_mask_r;
    pps_mask_nxt  = pps_mask_r;
    defv_nxt      = defv_r;
    defi_nxt      = defi_r;
    flog_nxt      = flog_r;
    if (wr_en) begin
      unique case (paddr)
        OPS_OFS_PROT: prot_nxt = pwdata[4:0];
        OPS_OFS_LEVEL: begin
          ovp_sel_nxt   = pwdata[1:0];
          uvp_sel_nxt   = pwdata[3:2];
          gpio_mode_nxt = pwdata[5:4];
          div_sel_nxt   = (pwdata[7:6] == 2'h3) ? div_sel_r : pwdata[7:6];
        end
        OPS_OFS_TEMP: begin
          otpi_code_nxt = (pwdata[4:0] > OPS_OTPI_MAX) ? OPS_OTPI_MAX : pwdata[4:0];
          otpe_lvl_nxt  = (pwdata[14:8] < OPS_OTPE_MIN) ? OPS_OTPE_MIN
                        : ((pwdata[14:8] > OPS_OTPE_MAX) ? OPS_OTPE_MAX : pwdata[14:8]);
        end
        OPS_OFS_PDO: begin
          // the fixed first PDO can be neither trip-mode nor programmable
          trip_mask_nxt = {pwdata[6:1], 1'b0};
          if (ops_popcnt({pwdata[14:9], 1'b0}) <= 4'(OPS_PPS_MAX)) begin
            pps_mask_nxt = {pwdata[14:9], 1'b0};
          end
        end
        OPS_OFS_DEFOUT: begin
          defv_nxt = (pwdata[7:0] > OPS_DEFV_MAX) ? OPS_DEFV_MAX : pwdata[7:0];
          defi_nxt = (pwdata[15:8] > OPS_DEFI_MAX) ? OPS_DEFI_MAX : pwdata[15:8];
        end
        OPS_OFS_FLOG: flog_nxt = flog_r & ~pwdata[8:0];
        default: ;
      endcase
    end
    flog_nxt = flog_nxt | fault;  // a new fault wins over a clear
  end

  // read data is captured in the setup cycle so it comes from a flop
  always_comb begin
    prdata_nxt = prdata_r;
    slverr_nxt = slverr_r;
    if (rd_setup) begin
      slverr_nxt = !mapped;
      prdata_nxt = 32'h0000_0000;
      unique case (paddr)
        OPS_OFS_PROT:   prdata_nxt = {27'h0, prot_r};
        OPS_OFS_LEVEL:  prdata_nxt = {24'h0, div_sel_r, gpio_mode_r, uvp_sel_r, ovp_sel_r};
        OPS_OFS_TEMP:   prdata_nxt = {17'h0, otpe_lvl_r, 3'h0, otpi_code_r};
        OPS_OFS_PDO:    prdata_nxt = {17'h0, pps_mask_r, 1'b0, trip_mask_r};
        OPS_OFS_DEFOUT: prdata_nxt = {16'h0, defi_r, defv_r};
        OPS_OFS_STATUS: prdata_nxt = {22'h0, load_switch_on, discharge_en, tmr_done,
                                      state_r, 3'h0, any_fault};
        OPS_OFS_FLOG:   prdata_nxt = {23'h0, flog_r};
        default:        prdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  // lockout returns every setting to its initial value, like a reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prot_r      <= OPS_PROT_RST;
      ovp_sel_r   <= 2'h0;
      uvp_sel_r   <= 2'h1;
      gpio_mode_r <= 2'h0;
      div_sel_r   <= 2'h0;
      otpi_code_r <= OPS_OTPI_RST;
      otpe_lvl_r  <= OPS_OTPE_RST;
      trip_mask_r <= 7'h00;
      pps_mask_r  <= 7'h00;
      defv_r      <= OPS_DEFV_RST;
      defi_r      <= OPS_DEFI_RST;
    end else if (supply_lockout) begin
      prot_r      <= OPS_PROT_RST;
      ovp_sel_r   <= 2'h0;
      uvp_sel_r   <= 2'h1;
      gpio_mode_r <= 2'h0;
      div_sel_r   <= 2'h0;
      otpi_code_r <= OPS_OTPI_RST;
      otpe_lvl_r  <= OPS_OTPE_RST;
      trip_mask_r <= 7'h00;
      pps_mask_r  <= 7'h00;
      defv_r      <= OPS_DEFV_RST;
      defi_r      <= OPS_DEFI_RST;
    end else begin
      prot_r      <= prot_nxt;
      ovp_sel_r   <= ovp_sel_nxt;
      uvp_sel_r   <= uvp_sel_nxt;
      gpio_mode_r <= gpio_mode_nxt;
      div_sel_r   <= div_sel_nxt;
      otpi_code_r <= otpi_code_nxt;
      otpe_lvl_r  <= otpe_lvl_nxt;
      trip_mask_r <= trip_mask_nxt;
      pps_mask_r  <= pps_mask_nxt;
      defv_r      <= defv_nxt;
      defi_r      <= defi_nxt;
    end
  end

  // sequencer state, fault log and bus answer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r  <= ST_RUN;
      flog_r   <= 9'h000;
      prdata_r <= 32'h0000_0000;
      slverr_r <= 1'b0;
    end else begin
      state_r  <= state_nxt;
      flog_r   <= flog_nxt;
      prdata_r <= prdata_nxt;
      slverr_r <= slverr_nxt;
    end
  end

  AST_SWITCH_OPEN_ON_FAULT: assert property (@(posedge pclk) disable iff (!presetn)
    any_fault |-> !load_switch_on) else $error("switch closed during fault");
  AST_RECLOSE_NEEDS_DEFAULT: assert property (@(posedge pclk) disable iff (!presetn)
    (state_r == ST_TRIP) && (state_nxt == ST_RUN) |-> tmr_done && vcc_at_default)
    else $error("reclosed before default level and delay");
  AST_TARGET_DEFAULT: assert property (@(posedge pclk) disable iff (!presetn)
    (state_r == ST_TRIP) |-> voltage_target == (OPS_V_3V + {1'b0, defv_r}))
    else $error("target not default during restart");
  AST_DISCHARGE: assert property (@(posedge pclk) disable iff (!presetn)
    discharge_en |-> (state_r == ST_TRIP) && vcc_above_105)
    else $error("discharge outside pending restart");
  AST_FAULT_LEAVES_RUN: assert property (@(posedge pclk) disable iff (!presetn)
    (state_r == ST_RUN) && any_fault |=> (state_r != ST_RUN) && !tmr_done)
    else $error("fault did not start restart timer");
  AST_LATCH_HOLDS: assert property (@(posedge pclk) disable iff (!presetn)
    (state_r == ST_LATCH) && !supply_lockout |=> state_r == ST_LATCH)
    else $error("latched fault released without lockout");
  AST_OVP_PCT: assert property (@(posedge pclk) disable iff (!presetn)
    (ovp_sel_r == 2'h0) && (voltage_target >= OPS_V_9V) |-> ovp_pct == OPS_PCT_120)
    else $error("wrong default overvoltage percent");
  AST_CC_DEFAULT_OFF: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(supply_lockout) |-> !prot_r[OPS_EN_CCOV] && (defv_r == OPS_DEFV_RST))
    else $error("settings not reset by lockout");
  AST_PPS_LIMIT: assert property (@(posedge pclk) disable iff (!presetn)
    ops_popcnt(pps_mask_r) <= 4'(OPS_PPS_MAX)) else $error("too many programmable PDOs");
endmodule
`default_nettype wire

// >>> dv/ops_partner.sv
/*
  ops_partner: supply model on the far side of the supervisor.
  Assumes the bench raises hot to push the supply above 1.05 x default.
*/
`timescale 1ns/10ps
`default_nettype none
module ops_partner (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic hot,
  input  wire logic discharge_en,
  output logic      vcc_above_105,
  output logic      vcc_at_default
);
  logic       above_r;
  logic [2:0] dis_r;
  // sink drains the supply in a few cycles, never at once
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      above_r <= 1'b0;
      dis_r   <= 3'h0;
    end else begin
      dis_r <= discharge_en ? dis_r + 3'h1 : 3'h0;
      if (hot)
        above_r <= 1'b1;
      else if (dis_r == 3'h3)
        above_r <= 1'b0;
    end
  end
  assign vcc_above_105  = above_r;
  assign vcc_at_default = !above_r;
endmodule
`default_nettype wire

// >>> dv/output_protection_supervisor_tb.sv
/*
  output_protection_supervisor_tb: APB register and fault sequences.
  Assumes short cc and overcurrent filter and restart counts set by parameter.
*/
`timescale 1ns/10ps
`default_nettype none
module output_protection_supervisor_tb;
  import ops_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, sl, os, ov, oc, uv, c1, c2, ss;
  logic hot, a105, adef, sw, dis, tdef, rseq, er;
  logic [10:0] dt;
  logic [6:0] nt;
  logic [2:0] ap;
  logic [7:0] paddr, ovp_pct, uvp_pct;
  logic [31:0] pwdata, prdata, q;
  logic [8:0] req, vt;
  int err_total, n_checks, k;
  ops_supervisor #(.CC_FILT_CYC(20), .OCP_BLANK_CYC(50), .RESTART_CYC(100)) u_ops_supervisor (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata),
    .supply_lockout(sl), .open_supply_guard(os), .ovp_above(ov), .ocp_above(oc),
    .uvp_below(uv), .cc1_above(c1), .cc2_above(c2), .cc_soft_short_guard(ss),
    .vcc_above_105(a105), .vcc_at_default(adef), .die_temp_dc(dt), .ntc_temp_c(nt),
    .req_voltage(req), .active_pdo(ap), .load_switch_on(sw), .discharge_en(dis),
    .target_default(tdef), .voltage_target(vt), .ovp_pct(ovp_pct), .uvp_pct(uvp_pct),
    .restart_seq(rseq));
  ops_partner u_ops_partner (.pclk(pclk), .presetn(presetn), .hot(hot),
    .discharge_en(dis), .vcc_above_105(a105), .vcc_at_default(adef));
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  task automatic test_done();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e) begin
      err_total++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  // apb transfer: hold the request until pready is seen at an edge
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    q = prdata;
    er = pslverr;
    if (k >= 50) begin
      err_total++;
      test_done();
    end
    psel <= 1'b0; penable <= 1'b0;
  endtask
  // waits for the switch level, returns cycles taken
  task automatic wsw(input logic v, input int n);
    k = 0;
    while (sw !== v && k < n) begin
      @(posedge pclk); #1;
      k++;
    end
    if (k >= n) begin
      err_total++;
      test_done();
    end
  endtask
  task automatic ovp_trip();
    ov <= 1'b1; hot <= 1'b1;
    wsw(1'b0, 3100);
    chk(k >= 2995 && k <= 3002, 1);
    // hold the fault across one more edge so the sequencer sees it
    @(posedge pclk);
    ov <= 1'b0; hot <= 1'b0;
  endtask
  initial begin
    {presetn, psel, penable, pwrite, sl, os, ov, oc, uv, c1, c2, ss, hot, dt, nt, ap} = '0;
    paddr = 8'h00; pwdata = 32'h0; req = 9'h064;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    // reset values and an unmapped place
    xfer(0, OPS_OFS_PROT, 0); chk(q, 32'h07);
    xfer(0, OPS_OFS_TEMP, 0); chk(q, 32'h5A14);
    xfer(0, OPS_OFS_DEFOUT, 0); chk(q, 32'h8728);
    xfer(0, 8'h1C, 0); chk(q, 32'h0);
    chk(er, 1);
    #1 chk(ovp_pct, 8'h7D);
    chk(uvp_pct, 8'h3C);
    req <= 9'h0B4;
    #10 chk(ovp_pct, 8'h78);
    chk(sw, 1);
    $display("test reset done");
    // broken overvoltage does not trip, unbroken one does
    ov <= 1'b1; repeat (2000) @(posedge pclk);
    ov <= 1'b0; #1 chk(sw, 1);
    @(posedge pclk);
    ovp_trip();
    @(posedge pclk); #1 chk(tdef, 1);
    chk(dis, 1);
    chk(vt, 9'h064);
    k = 0;
    while (rseq !== 1'b1 && k < 120) begin
      @(posedge pclk); #1; k++;
    end
    chk(k > 90 && k < 120, 1);
    wsw(1'b1, 20);
    $display("test restart done");
    // latched mode survives the timer, lockout clears it
    xfer(1, OPS_OFS_PROT, 32'h17);
    ovp_trip();
    repeat (150) @(posedge pclk);
    #1 chk(sw, 0);
    sl <= 1'b1; repeat (3) @(posedge pclk);
    #1 chk(sw, 0);
    sl <= 1'b0;
    xfer(0, OPS_OFS_PROT, 0); chk(q, 32'h07);
    wsw(1'b1, 130);
    $display("test latch done");
    // soft short opens at once, cc overvoltage after its filter
    ss <= 1'b1; #1 chk(sw, 0);
    ss <= 1'b0; wsw(1'b1, 130);
    os <= 1'b1; #1 chk(sw, 0);
    os <= 1'b0; wsw(1'b1, 130);
    xfer(1, OPS_OFS_PROT, 32'h0F);
    c2 <= 1'b1; wsw(1'b0, 30);
    chk(k >= 18 && k <= 22, 1);
    c2 <= 1'b0;
    $display("test immediate done");
    // trip levels, divider cap and trip-mode PDO selection
    xfer(1, OPS_OFS_PDO, 32'h7E03);
    xfer(0, OPS_OFS_PDO, 0); chk(q, 32'h02);
    xfer(1, OPS_OFS_PDO, 32'h1E03);
    xfer(0, OPS_OFS_PDO, 0); chk(q, 32'h1E02);
    nt <= 7'h5B; dt <= 11'h46A; oc <= 1'b1;
    #1 chk(sw, 1);
    xfer(1, OPS_OFS_LEVEL, 32'h64);
    #1 chk(vt, 9'h078);
    chk(sw, 0);
    @(posedge pclk);
    nt <= 7'h19;
    wsw(1'b1, 130);
    dt <= 11'h46B; #1 chk(sw, 0);
    dt <= 11'h000; ap <= 3'h1;
    #1 chk(uvp_pct, 8'h46);
    wsw(1'b0, 60);
    chk(k >= 48 && k <= 52, 1);
    oc <= 1'b0;
    $display("test config done");
    test_done();
  end
endmodule
`default_nettype wire
